// File: logic/tios_responder.v
// Notes on behaviour
// - test-device only reports, changes no state
// - test-device cc: 00 known, 11 unknown, 10 busy
// - acknowledge cc: 00 normal, 01 unusual, 11 none
// - acknowledge returns source address and cause
// - operation starts only on accepted start
// - accepted start then requests order byte
// - status bit 0 shows pending interrupt
// - pending controller interrupt refuses start, chaining allowed
// - status bits 1,2 encode station state
// - bit 3 automatic; manual holds tape motion
// - bit 4 unusual end since last order
// - bits 5,6: 00 standby, 11 busy
// - detailed bit 0 rate error last transfer
// - write rate error emits filler until data
// - detailed bit 1 set when writing permitted
// - detailed bit 1 clear when write protected
// - detailed bit 2 write to protected device
`include "tios_regs.vh"
module tios_responder #(
  parameter AW = 3  // station number width
) (
  // clock and reset
  input  wire          clk_in,
  input  wire          rst_n_in,
  // instruction port from the io_processor
  input  wire          instr_valid_in,     // one-cycle instruction strobe
  input  wire [2:0]    instr_code_in,      // start/halt/test/tdev/ack
  input  wire [7:0]    instr_addr_in,      // addressed device
  input  wire          selector_busy_in,   // io_processor selector busy
  input  wire [7:0]    ctrl_addr_in,       // controller address switches
  // station pins (asynchronous)
  input  wire          st_present_in,      // station online
  input  wire          st_operational_in,
  input  wire          st_auto_in,         // automatic mode selected
  input  wire          st_rewinding_in,
  input  wire          st_write_ring_in,   // write enable ring fitted
  input  wire          st_dev_irq_in,      // device end interrupt request
  // controller events (same clock)
  input  wire          order_valid_in,     // order byte delivered
  input  wire [7:0]    order_in,
  input  wire          chain_in,           // command chaining request
  input  wire          op_done_in,         // operation end pulse
  input  wire          op_unusual_in,      // unusual condition pulse
  input  wire          term_irq_in,        // terminal order asks interrupt
  input  wire          rate_err_in,        // overrun pulse
  input  wire          wr_byte_valid_in,   // host write byte present
  input  wire          wr_slot_in,         // tape needs a byte now
  input  wire [7:0]    wr_byte_in,
  // responses
  output reg           resp_valid_out,
  output reg  [1:0]    cc_out,             // {condition_code_high,_low}
  output reg  [7:0]    status_out,
  output reg  [7:0]    ack_addr_out,       // interrupting source
  output reg           order_req_out,      // order byte request
  output reg           op_active_out,      // controller busy
  output reg           motion_en_out,      // tape motion allowed
  output reg           wr_strobe_out,
  output reg  [7:0]    wr_char_out
);
  // two-flop synchronisers for station pins
  reg [5:0] sync_a;
  reg [5:0] sync_b;
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync_a <= 6'h00;
      sync_b <= 6'h00;
    end else begin
      sync_a <= {st_present_in, st_operational_in, st_auto_in,
                 st_rewinding_in, st_write_ring_in, st_dev_irq_in};
      sync_b <= sync_a;
    end
  end
  wire present  = sync_b[5];
  wire oper     = sync_b[4];
  wire auto_md  = sync_b[3];
  wire rewind   = sync_b[2];
  wire wr_ring  = sync_b[1];
  wire dev_irq  = sync_b[0];

  // controller state
  reg       busy;          // executing an operation
  reg       ctl_irq;       // controller interrupt pending
  reg       irq_unusual;   // cause of pending interrupt
  reg       unusual;       // unusual since last order
  reg       rate_err;      // overrun in last transfer
  reg       wp_viol;       // write ordered onto protected device
  reg       writing;       // current order is a write
  reg [7:0] active_addr;   // device owning the operation

  // decode helpers
  function is_write;
    input [7:0] ord;
    begin
      is_write = (ord[1:0] == 2'h1);
    end
  endfunction
  function [7:0] common_status;
    input irq, op, rw, at, un, bz;
    begin
      common_status = `TIOS_STATUS_RST;
      common_status[`TIOS_CS_IRQ]    = irq;
      common_status[`TIOS_CS_DEV_HI] = op & (bz | rw);
      common_status[`TIOS_CS_DEV_LO] = ~op | bz | rw;
      common_status[`TIOS_CS_AUTO]   = at;
      common_status[`TIOS_CS_UNUSUAL] = un;
      common_status[`TIOS_CS_CTL_HI] = bz;
      common_status[`TIOS_CS_CTL_LO] = bz;
      common_status[`TIOS_CS_SPARE]  = 1'b0;
    end
  endfunction

  wire addr_ok  = present && (instr_addr_in == ctrl_addr_in);
  wire irq_pend = ctl_irq | dev_irq;
  // start only when idle, ready and nothing pending
  wire start_ok = !busy && oper && !rewind && !irq_pend;
  wire [7:0] cs = common_status(irq_pend, oper, rewind, auto_md, unusual, busy);

  // per-station memory of write-protect violation, indexed by device
  wire       mem_rd;  // violation flag of the active station, one cycle late
  tios_status_mem #(.AW(AW), .DW(1)) u_mem (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n_in),
    .wr_en_in    (order_valid_in),
    .wr_addr_in  (active_addr[AW-1:0]),
    .wr_data_in  (is_write(order_in) & ~wr_ring),
    .rd_addr_in  (active_addr[AW-1:0]),
    .rd_data_out (mem_rd)
  );

  // controller state machine; set beats clear for every flag except busy, where op_done_in wins over a start
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy        <= 1'b0;
      ctl_irq     <= 1'b0;
      irq_unusual <= 1'b0;
      unusual     <= 1'b0;
      rate_err    <= 1'b0;
      wp_viol     <= 1'b0;
      writing     <= 1'b0;
      active_addr <= 8'h00;
      order_req_out <= 1'b0;
    end else begin
      // order request drops once the order arrives
      if (order_valid_in) begin
        order_req_out <= 1'b0;
        writing <= is_write(order_in);
        wp_viol <= is_write(order_in) & ~wr_ring;
        unusual <= op_unusual_in;
        rate_err <= 1'b0;                          // new transfer
      end else if (op_unusual_in) begin
        unusual <= 1'b1;
      end
      if (rate_err_in) begin
        rate_err <= 1'b1;
      end
      // acknowledge carries no device address; the priority chain picks us
      if (instr_valid_in && instr_code_in == `TIOS_INSTR_ACK) begin
        ctl_irq <= 1'b0;                           // a new request below wins
      end else if (instr_valid_in && addr_ok) begin
        // tdev and test reach this branch but change nothing
        if (instr_code_in == `TIOS_INSTR_START && start_ok &&
            !selector_busy_in) begin
          busy          <= 1'b1;
          active_addr   <= instr_addr_in;
          order_req_out <= 1'b1;
        end else if (instr_code_in == `TIOS_INSTR_HALT) begin
          busy          <= 1'b0;
          order_req_out <= 1'b0;
          if (instr_addr_in == active_addr) begin
            ctl_irq <= 1'b0;
          end
        end
      end
      // chaining continues despite a pending interrupt
      if (chain_in && busy) begin
        order_req_out <= 1'b1;
      end
      if (op_done_in) begin
        busy <= 1'b0;
      end
      if (term_irq_in) begin
        ctl_irq     <= 1'b1;
        irq_unusual <= unusual | op_unusual_in;
      end
    end
  end

  // response builder: cc, status, source address
  reg [1:0] next_cc;
  reg [7:0] next_st;
  always @* begin
    next_cc = `TIOS_CC_NO_ADDR;
    next_st = `TIOS_STATUS_RST;
    case (instr_code_in)
      `TIOS_INSTR_START, `TIOS_INSTR_TEST: begin
        next_st = cs;
        if (!addr_ok) begin
          next_cc = `TIOS_CC_NO_ADDR;
        end else if (selector_busy_in) begin
          next_cc = `TIOS_CC_SEL_BUSY;
        end else if (start_ok) begin
          next_cc = `TIOS_CC_OK;
        end else begin
          next_cc = `TIOS_CC_REFUSED;
        end
      end
      `TIOS_INSTR_HALT: begin
        next_st = cs;
        if (!addr_ok) begin
          next_cc = `TIOS_CC_NO_ADDR;
        end else begin
          next_cc = busy ? `TIOS_CC_REFUSED : `TIOS_CC_OK;
        end
      end
      `TIOS_INSTR_TDEV: begin
        // detailed status; pure read
        next_st[`TIOS_DS_RATE]    = rate_err;
        next_st[`TIOS_DS_WR_OK]   = wr_ring;
        next_st[`TIOS_DS_WP_VIOL] = wp_viol;
        if (!addr_ok) begin
          next_cc = `TIOS_CC_NO_ADDR;
        end else if (selector_busy_in) begin
          next_cc = `TIOS_CC_SEL_BUSY;
        end else begin
          next_cc = `TIOS_CC_OK;
        end
      end
      `TIOS_INSTR_ACK: begin
        // cause in status, source in ack_addr
        next_st[`TIOS_DS_RATE]    = rate_err;
        next_st[`TIOS_DS_WR_OK]   = ~ctl_irq & dev_irq;
        next_st[`TIOS_DS_WP_VIOL] = mem_rd;
        if (ctl_irq) begin
          next_cc = irq_unusual ? `TIOS_CC_REFUSED : `TIOS_CC_OK;
        end else if (dev_irq) begin
          next_cc = `TIOS_CC_OK;
        end else begin
          next_cc = `TIOS_CC_NO_ADDR;
        end
      end
      default: begin
        next_cc = `TIOS_CC_NO_ADDR;
      end
    endcase
  end

  // registered outputs
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      resp_valid_out <= 1'b0;
      cc_out         <= `TIOS_CC_RST;
      status_out     <= `TIOS_STATUS_RST;
      ack_addr_out   <= 8'h00;
      op_active_out  <= 1'b0;
      motion_en_out  <= 1'b0;
    end else begin
      resp_valid_out <= instr_valid_in;
      if (instr_valid_in) begin
        cc_out       <= next_cc;
        status_out   <= next_st;
        ack_addr_out <= ctl_irq ? active_addr : ctrl_addr_in;
      end
      op_active_out <= busy;
      // manual mode holds tape motion until automatic
      motion_en_out <= busy & auto_md;
    end
  end

  // write path: filler when host byte is late
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_strobe_out <= 1'b0;
      wr_char_out   <= 8'h00;
    end else begin
      wr_strobe_out <= wr_slot_in & busy & writing;
      if (wr_slot_in) begin
        wr_char_out <= wr_byte_valid_in ? wr_byte_in : `TIOS_FILL_CHAR;
      end
    end
  end
endmodule

// File: pkg/tios_regs.vh
`ifndef TIOS_REGS_VH
`define TIOS_REGS_VH
// instruction codes on the host command port
`define TIOS_INSTR_START   3'h0
`define TIOS_INSTR_HALT    3'h1
`define TIOS_INSTR_TEST    3'h2
`define TIOS_INSTR_TDEV    3'h3
`define TIOS_INSTR_ACK     3'h4
// condition codes {high,low}
`define TIOS_CC_OK         2'h0
`define TIOS_CC_REFUSED    2'h1
`define TIOS_CC_SEL_BUSY   2'h2
`define TIOS_CC_NO_ADDR    2'h3
// common status byte field positions
`define TIOS_CS_IRQ        0
`define TIOS_CS_DEV_HI     1
`define TIOS_CS_DEV_LO     2
`define TIOS_CS_AUTO       3
`define TIOS_CS_UNUSUAL    4
`define TIOS_CS_CTL_HI     5
`define TIOS_CS_CTL_LO     6
`define TIOS_CS_SPARE      7
// detailed status byte field positions
`define TIOS_DS_RATE       0
`define TIOS_DS_WR_OK      1
`define TIOS_DS_WP_VIOL    2
// reset values
`define TIOS_STATUS_RST    8'h00
`define TIOS_CC_RST        2'h3
`define TIOS_FILL_CHAR     8'h00
`endif

// File: logic/tios_status_mem.v
// per-station memory of latched conditions; registered read data
module tios_status_mem #(
  parameter AW = 3,
  parameter DW = 3
) (
  // clock and reset
  input  wire          clk_in,
  input  wire          rst_n_in,
  // write port
  input  wire          wr_en_in,
  input  wire [AW-1:0] wr_addr_in,
  input  wire [DW-1:0] wr_data_in,
  // read port
  input  wire [AW-1:0] rd_addr_in,
  output reg  [DW-1:0] rd_data_out
);
  reg [DW-1:0] mem [0:(1<<AW)-1];  // one word per station
  integer i;

  // storage; cleared at reset so no station starts with stale flags
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (i = 0; i < (1<<AW); i = i + 1) begin
        mem[i] <= {DW{1'b0}};
      end
    end else if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  // registered read, one cycle latency
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_data_out <= {DW{1'b0}};
    end else begin
      rd_data_out <= mem[rd_addr_in];
    end
  end
endmodule

// File: sim/tios_check_sva.sv
`include "tios_regs.vh"
module tios_check_sva (
  // clock and reset
  input wire       clk_in,
  input wire       rst_n_in,
  // instruction side
  input wire       instr_valid_in,
  input wire       selector_busy_in,
  input wire       order_valid_in,
  input wire       chain_in,
  input wire       op_done_in,
  input wire [2:0] instr_code_in,
  input wire [7:0] instr_addr_in,
  input wire [7:0] ctrl_addr_in,
  // answers
  input wire       resp_valid_out,
  input wire       order_req_out,
  input wire       op_active_out,
  input wire       motion_en_out,
  input wire [1:0] cc_out,
  input wire [7:0] status_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // addressed instruction, and whether it names this controller
  wire addr_cmd = instr_valid_in && instr_code_in != `TIOS_INSTR_ACK;
  wire hit      = instr_addr_in == ctrl_addr_in;
  a_resp_one_cycle: assert property (instr_valid_in |=> resp_valid_out)
    else $error("answer missing one cycle after instruction");
  a_resp_no_cause: assert property (!instr_valid_in |=> !resp_valid_out)
    else $error("answer without instruction");
  a_addr_unknown: assert property (addr_cmd && !hit |=> cc_out == `TIOS_CC_NO_ADDR)
    else $error("foreign address not answered 11");
  a_tdev_sel_busy: assert property (instr_valid_in && hit && selector_busy_in
    && instr_code_in == `TIOS_INSTR_TDEV |=> cc_out == `TIOS_CC_SEL_BUSY)
    else $error("busy selector not answered 10");
  a_common_fields: assert property (resp_valid_out && $past(instr_code_in) < 3
    |-> !status_out[7] && status_out[5] == status_out[6] && (status_out[2] || !status_out[1]))
    else $error("unused code in common status");
  a_order_drop: assert property (order_valid_in && !instr_valid_in && !chain_in
    |=> !order_req_out)
    else $error("order request kept after order");
  // chaining may raise the request as well as an accepted start
  a_order_cause: assert property ($rose(order_req_out) |->
    $past(instr_valid_in && instr_code_in == `TIOS_INSTR_START || chain_in))
    else $error("order request without instruction");
  a_start_order: assert property (instr_valid_in && instr_code_in == `TIOS_INSTR_START
    ##1 cc_out == `TIOS_CC_OK |-> order_req_out)
    else $error("accepted start asks no order");
  a_motion_busy: assert property (motion_en_out |-> op_active_out)
    else $error("tape motion while idle");
  // op_active_out lags busy by one cycle: skip the cycle after an end or a halt
  a_busy_refuse: assert property (instr_valid_in && hit && op_active_out
    && !$past(op_done_in) && !$past(instr_valid_in && instr_code_in == `TIOS_INSTR_HALT)
    && !selector_busy_in && instr_code_in == `TIOS_INSTR_START |=> cc_out == `TIOS_CC_REFUSED)
    else $error("start taken while busy");
  c_start_ok: cover property (instr_valid_in && instr_code_in == 0 ##1 cc_out == 0);
  c_order: cover property (order_req_out && order_valid_in);
  c_refused: cover property (resp_valid_out && cc_out == `TIOS_CC_REFUSED);
endmodule
bind tios_responder tios_check_sva u_check (
  .clk_in           (clk_in),
  .rst_n_in         (rst_n_in),
  .instr_valid_in   (instr_valid_in),
  .selector_busy_in (selector_busy_in),
  .order_valid_in   (order_valid_in),
  .chain_in         (chain_in),
  .op_done_in       (op_done_in),
  .instr_code_in    (instr_code_in),
  .instr_addr_in    (instr_addr_in),
  .ctrl_addr_in     (ctrl_addr_in),
  .resp_valid_out   (resp_valid_out),
  .order_req_out    (order_req_out),
  .op_active_out    (op_active_out),
  .motion_en_out    (motion_en_out),
  .cc_out           (cc_out),
  .status_out       (status_out)
);

// File: sim/tios_iop_model.sv
// io_processor side: hands over the order byte some edges after the request
module tios_iop_model #(parameter DELAY = 2) (
  // clock and reset
  input  wire       clk_in,
  input  wire       rst_n_in,
  // order link
  input  wire       order_req_in,
  input  wire [7:0] order_byte_in,
  output reg        order_valid_out,
  output reg  [7:0] order_out
);
  timeunit 1ns;
  timeprecision 1ns;
  integer wait_cnt;  // edges the request has stood
  // drives at the falling edge so the controller samples settled values
  always @(negedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wait_cnt <= 0;
      order_valid_out <= 1'b0;
      order_out <= 8'h00;
    end else if (order_valid_out) begin
      // released byte shows junk, never the old order
      wait_cnt <= 0;
      order_valid_out <= 1'b0;
      order_out <= ~order_out;
    end else if (order_req_in) begin
      wait_cnt <= wait_cnt + 1;
      if (wait_cnt >= DELAY) begin
        order_valid_out <= 1'b1;
        order_out <= order_byte_in;
      end
    end
  end
endmodule

// File: sim/testbench.sv
`include "tios_regs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // short forms of instruction and condition codes
  localparam [2:0] I_ST = `TIOS_INSTR_START, I_TS = `TIOS_INSTR_TEST, I_TD = `TIOS_INSTR_TDEV;
  localparam [2:0] I_AK = `TIOS_INSTR_ACK;
  localparam [1:0] OK = `TIOS_CC_OK, RF = `TIOS_CC_REFUSED, SB = `TIOS_CC_SEL_BUSY;
  localparam [1:0] NA = `TIOS_CC_NO_ADDR;
  localparam [7:0] CTL = 8'h5a, ALT = 8'hda;  // our address, a foreign one
  // driven inputs
  reg        clk_in, rst_n_in, instr_valid_in, selector_busy_in, st_operational_in;
  reg        st_auto_in, st_write_ring_in, st_dev_irq_in, op_done_in, op_unusual_in;
  reg        term_irq_in, rate_err_in, wr_byte_valid_in, wr_slot_in;
  reg  [2:0] instr_code_in;
  reg  [7:0] instr_addr_in;
  // fixed inputs: no rewind, no chaining, one write byte
  wire       st_present_in = 1'b1;
  wire       st_rewinding_in = 1'b0;
  wire       chain_in = 1'b0;
  wire [7:0] ctrl_addr_in = CTL;
  wire [7:0] wr_byte_in = 8'ha5;
  // outputs and the order link
  wire       resp_valid_out, order_req_out, op_active_out, motion_en_out, wr_strobe_out;
  wire       order_valid_in;
  wire [1:0] cc_out;
  wire [7:0] status_out, ack_addr_out, wr_char_out, order_in;
  integer    err_total, compares, i;
  tios_responder #(.AW(3)) dut (
    .clk_in            (clk_in),
    .rst_n_in          (rst_n_in),
    .instr_valid_in    (instr_valid_in),
    .instr_code_in     (instr_code_in),
    .instr_addr_in     (instr_addr_in),
    .selector_busy_in  (selector_busy_in),
    .ctrl_addr_in      (ctrl_addr_in),
    .st_present_in     (st_present_in),
    .st_operational_in (st_operational_in),
    .st_auto_in        (st_auto_in),
    .st_rewinding_in   (st_rewinding_in),
    .st_write_ring_in  (st_write_ring_in),
    .st_dev_irq_in     (st_dev_irq_in),
    .order_valid_in    (order_valid_in),
    .order_in          (order_in),
    .chain_in          (chain_in),
    .op_done_in        (op_done_in),
    .op_unusual_in     (op_unusual_in),
    .term_irq_in       (term_irq_in),
    .rate_err_in       (rate_err_in),
    .wr_byte_valid_in  (wr_byte_valid_in),
    .wr_slot_in        (wr_slot_in),
    .wr_byte_in        (wr_byte_in),
    .resp_valid_out    (resp_valid_out),
    .cc_out            (cc_out),
    .status_out        (status_out),
    .ack_addr_out      (ack_addr_out),
    .order_req_out     (order_req_out),
    .op_active_out     (op_active_out),
    .motion_en_out     (motion_en_out),
    .wr_strobe_out     (wr_strobe_out),
    .wr_char_out       (wr_char_out)
  );
  tios_iop_model #(.DELAY(2)) u_iop (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .order_req_in(order_req_out), .order_byte_in(8'h01), .order_valid_out(order_valid_in),
    .order_out(order_in));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  task chk(input [7:0] got, input [7:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // one instruction from a falling edge; answer seen one edge later
  // a quiet cycle follows so the strobe never toggles twice in one step
  task io(input [2:0] code, input [7:0] addr, input [1:0] ecc);
    begin
      instr_valid_in = 1'b1;
      instr_code_in = code;
      instr_addr_in = addr;
      @(negedge clk_in);
      instr_valid_in = 1'b0;
      chk({resp_valid_out, 5'h00, cc_out}, {6'h20, ecc});
      @(negedge clk_in);
    end
  endtask
  task conclude;
    begin
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // accepted start, then wait a bounded time for the order to be taken
  task run_start;
    begin
      io(I_ST, CTL, OK);
      for (i = 0; i < 20 && order_req_out !== 1'b0; i = i + 1)
        @(negedge clk_in);
      if (i == 20) begin
        err_total = err_total + 1;
        conclude;
      end
    end
  endtask
  initial begin
    {rst_n_in, instr_valid_in, selector_busy_in, st_dev_irq_in, wr_byte_valid_in} = 5'h00;
    {op_done_in, op_unusual_in, term_irq_in, rate_err_in, wr_slot_in} = 5'h00;
    {st_operational_in, st_auto_in, st_write_ring_in} = 3'h7;
    instr_code_in = 3'h0;
    instr_addr_in = 8'h00;
    err_total = 0;
    compares = 0;
    repeat (20) @(negedge clk_in);
    rst_n_in = 1'b1;
    repeat (3) @(negedge clk_in);
    io(I_TD, ALT, NA);
    selector_busy_in = 1'b1;
    io(I_TD, CTL, SB);
    selector_busy_in = 1'b0;
    io(I_TD, CTL, OK);
    chk(status_out, 8'h02);
    io(I_TS, CTL, OK);
    chk(status_out, 8'h08);
    io(I_AK, CTL, NA);
    st_operational_in = 1'b0;
    repeat (3) @(negedge clk_in);
    io(I_TS, CTL, RF);
    chk(status_out, 8'h0c);
    st_operational_in = 1'b1;
    repeat (3) @(negedge clk_in);
    $display("test idle_status done");
    run_start;
    chk({7'h00, motion_en_out}, 8'h01);
    io(I_TS, CTL, RF);
    chk(status_out, 8'h6e);
    io(I_ST, CTL, RF);
    {term_irq_in, op_unusual_in, op_done_in, rate_err_in} = 4'h1;
    wr_slot_in = 1'b1;
    @(negedge clk_in);
    {term_irq_in, op_unusual_in, op_done_in, rate_err_in} = 4'h0;
    chk({wr_strobe_out, 7'h00} | wr_char_out, 8'h80);
    wr_byte_valid_in = 1'b1;
    @(negedge clk_in);
    wr_slot_in = 1'b0;
    chk(wr_char_out, 8'ha5);
    io(I_TD, CTL, OK);
    chk(status_out, 8'h03);
    chk({7'h00, op_active_out}, 8'h01);
    $display("test write_transfer done");
    {term_irq_in, op_unusual_in, op_done_in, rate_err_in} = 4'he;
    @(negedge clk_in);
    {term_irq_in, op_unusual_in, op_done_in, rate_err_in} = 4'h0;
    @(negedge clk_in);
    io(I_TS, CTL, RF);
    chk(status_out, 8'h19);
    io(I_ST, CTL, RF);
    // acknowledge is not addressed: any address, source comes back
    io(I_AK, ALT, RF);
    chk(ack_addr_out, CTL);
    chk(status_out, 8'h01);
    io(I_AK, ALT, NA);
    st_dev_irq_in = 1'b1;
    repeat (3) @(negedge clk_in);
    io(I_AK, CTL, OK);
    chk(status_out, 8'h03);
    st_dev_irq_in = 1'b0;
    $display("test interrupts done");
    st_write_ring_in = 1'b0;
    st_auto_in = 1'b0;
    repeat (3) @(negedge clk_in);
    run_start;
    chk({7'h00, motion_en_out}, 8'h00);
    io(I_TS, CTL, RF);
    chk(status_out, 8'h66);
    io(I_TD, CTL, OK);
    chk(status_out & 8'h06, 8'h04);
    st_auto_in = 1'b1;
    repeat (4) @(negedge clk_in);
    chk({7'h00, motion_en_out}, 8'h01);
    $display("test write_protect done");
    conclude;
  end
endmodule
